// >>> hdl/host_port_dsp_side_datapath.sv
// DSP-side datapath of the byte-wide parallel host port
`timescale 1ns/1ps
module host_port_dsp_side_datapath
	import host_port_pkg::*;
(
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic soft_reset_i,
	input wire logic stop_reset_i,
	input wire logic [1:0] port_configuration_i,
	input wire logic [1:0] dsp_sel_i,
	input wire logic dsp_rd_i,
	input wire logic dsp_wr_i,
	input wire logic [WORD_W-1:0] dsp_wdata_i,
	output logic [WORD_W-1:0] dsp_rdata_o,
	input wire logic irq_ack_cmd_i,
	output logic receive_irq_o,
	output logic transmit_irq_o,
	output logic command_irq_o,
	output logic [VEC_W-1:0] command_vector_o,
	input wire logic [BYTE_W-1:0] host_data_i,
	output logic [BYTE_W-1:0] host_data_o,
	output logic host_data_oe_o,
	input wire logic [2:0] register_select_lines_i,
	input wire logic host_cs_n_i,
	input wire logic host_rd_n_i,
	input wire logic host_wr_n_i,
	input wire logic host_acknowledge_pin_n_i,
	output logic host_request_pin_n_o
);
	typedef struct packed {
		logic receive_irq_enable;
		logic transmit_irq_enable;
		logic command_irq_enable;
		logic dsp_to_host_flag_a;
		logic dsp_to_host_flag_b;
		logic dsp_receive_full;
		logic dsp_transmit_empty;
		logic host_receive_full;
		logic host_transmit_empty;
		logic command_pending;
		logic [VEC_W-1:0] command_vector;
		logic host_to_dsp_flag_a;
		logic host_to_dsp_flag_b;
		logic transfer_mode_low;
		logic transfer_mode_high;
		logic rx_req_enable;
		logic tx_req_enable;
		logic [BYTE_W-1:0] host_irq_vector;
		logic [1:0] dma_cnt;
		logic wr_prev;
		logic rd_prev;
		logic acc_dma;
		logic [2:0] acc_addr;
		logic [BYTE_W-1:0] wr_byte;
		logic [BYTE_W-1:0] host_out;
		logic host_oe;
		logic host_req_n;
		logic [WORD_W-1:0] rdata;
		logic rx_irq;
		logic tx_irq;
		logic cmd_irq;
	} state_t;

	// Data words carry no reset, so they sit apart from the flag state
	typedef struct packed {
		logic [WORD_W-1:0] dsp_receive_word;
		logic [WORD_W-1:0] dsp_transmit_word;
		logic [WORD_W-1:0] host_transmit_bytes;
		logic [WORD_W-1:0] host_receive_bytes;
	} data_t;

	state_t st_q;
	state_t st_d;
	data_t dt_q;
	data_t dt_d;

	logic [SYNC_W-1:0] pins_s;
	logic pin_ack_n;
	logic pin_cs_n;
	logic pin_rd_n;
	logic pin_wr_n;
	logic [2:0] pin_addr;
	logic [BYTE_W-1:0] pin_data;
	logic dma_on;
	logic dma_acc;
	logic wr_act;
	logic rd_act;
	logic wr_end;
	logic rd_end;
	logic [2:0] acc_addr;
	logic sync_rst;
	logic rx_move;
	logic tx_move;
	logic dsp_rx_rd;
	logic dsp_tx_wr;
	logic dsp_ctl_wr;

	////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] dsp_status(input state_t s);
		logic [7:0] v;
		v = 8'h00;
		v[ST_RX_FULL] = s.dsp_receive_full;
		v[ST_TX_EMPTY] = s.dsp_transmit_empty;
		v[ST_CMD] = s.command_pending;
		v[ST_FLAG_A] = s.host_to_dsp_flag_a;
		v[ST_FLAG_B] = s.host_to_dsp_flag_b;
		v[ST_DMA] = s.transfer_mode_low | s.transfer_mode_high;
		return v;
	endfunction

	function automatic logic host_req(input state_t s);
		return (s.rx_req_enable & s.host_receive_full) |
			(s.tx_req_enable & s.host_transmit_empty);
	endfunction

	function automatic logic [7:0] host_byte(input state_t s, input data_t d,
		input logic [2:0] a);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			HA_CONTROL: begin
				v[HC_RX_REQ] = s.rx_req_enable;
				v[HC_TX_REQ] = s.tx_req_enable;
				v[HC_FLAG_A] = s.host_to_dsp_flag_a;
				v[HC_FLAG_B] = s.host_to_dsp_flag_b;
				v[HC_MODE_LO] = s.transfer_mode_low;
				v[HC_MODE_HI] = s.transfer_mode_high;
			end
			HA_VECTOR: v = {s.command_pending, s.command_vector};
			HA_STATUS: begin
				v[HS_RX_FULL] = s.host_receive_full;
				v[HS_TX_EMPTY] = s.host_transmit_empty;
				v[HS_TX_READY] = s.host_transmit_empty & ~s.dsp_receive_full;
				v[HS_FLAG_A] = s.dsp_to_host_flag_a;
				v[HS_FLAG_B] = s.dsp_to_host_flag_b;
				v[HS_REQ] = host_req(s);
			end
			HA_IRQ_VEC: v = s.host_irq_vector;
			HA_HIGH: v = d.host_receive_bytes[23:16];
			HA_MID: v = d.host_receive_bytes[15:8];
			HA_LOW: v = d.host_receive_bytes[7:0];
			default: v = 8'h00;
		endcase
		return v;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Host pins cross into the DSP clock before anything reads them
	pin_sync #(.W(SYNC_W), .IDLE(PIN_IDLE)) u_pin_sync (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.async_i({host_acknowledge_pin_n_i, host_cs_n_i, host_rd_n_i,
			host_wr_n_i, register_select_lines_i, host_data_i}),
		.sync_o(pins_s)
	);

	assign pin_ack_n = pins_s[14];
	assign pin_cs_n = pins_s[13];
	assign pin_rd_n = pins_s[12];
	assign pin_wr_n = pins_s[11];
	assign pin_addr = pins_s[10:8];
	assign pin_data = pins_s[7:0];

	assign dma_on = st_q.transfer_mode_low | st_q.transfer_mode_high;
	// Acknowledge only selects a data byte while a DMA mode is on
	assign dma_acc = dma_on & ~pin_ack_n;
	assign wr_act = ~pin_wr_n & (~pin_cs_n | dma_acc);
	assign rd_act = ~pin_rd_n & (~pin_cs_n | dma_acc);
	assign wr_end = st_q.wr_prev & ~wr_act;
	assign rd_end = st_q.rd_prev & ~rd_act;
	// Counter stands in for the select lines during DMA
	assign acc_addr = dma_acc ? {1'b1, st_q.dma_cnt} : pin_addr;

	assign sync_rst = soft_reset_i | stop_reset_i |
		(port_configuration_i == CFG_OFF);
	// Each direction moves on its own flags only, so DMA in one
	// direction leaves the other free for polling
	assign rx_move = ~st_q.host_transmit_empty &
		~st_q.dsp_receive_full;
	assign tx_move = ~st_q.dsp_transmit_empty &
		~st_q.host_receive_full;
	assign dsp_rx_rd = dsp_rd_i & (dsp_sel_i == SEL_DATA);
	assign dsp_tx_wr = dsp_wr_i & (dsp_sel_i == SEL_DATA);
	assign dsp_ctl_wr = dsp_wr_i & (dsp_sel_i == SEL_CONTROL);

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		st_d = st_q;
		dt_d = dt_q;
		st_d.wr_prev = wr_act;
		st_d.rd_prev = rd_act;
		if (wr_act) begin
			st_d.wr_byte = pin_data;
		end
		if (wr_act | rd_act) begin
			st_d.acc_addr = acc_addr;
			st_d.acc_dma = dma_acc;
		end
		// DSP side accesses
		if (dsp_ctl_wr) begin
			st_d.receive_irq_enable = dsp_wdata_i[CTL_RX_IE];
			st_d.transmit_irq_enable = dsp_wdata_i[CTL_TX_IE];
			st_d.command_irq_enable = dsp_wdata_i[CTL_CMD_IE];
			st_d.dsp_to_host_flag_a = dsp_wdata_i[CTL_FLAG_A];
			st_d.dsp_to_host_flag_b = dsp_wdata_i[CTL_FLAG_B];
		end
		if (dsp_tx_wr) begin
			dt_d.dsp_transmit_word = dsp_wdata_i;
			st_d.dsp_transmit_empty = 1'b0;
		end
		if (dsp_rx_rd) begin
			st_d.dsp_receive_full = 1'b0;
		end
		if (irq_ack_cmd_i) begin
			st_d.command_pending = 1'b0;
		end
		// Host writes land when the strobe ends
		if (wr_end) begin
			case (st_q.acc_addr)
				HA_CONTROL: begin
					st_d.rx_req_enable = st_q.wr_byte[HC_RX_REQ];
					st_d.tx_req_enable = st_q.wr_byte[HC_TX_REQ];
					st_d.host_to_dsp_flag_a = st_q.wr_byte[HC_FLAG_A];
					st_d.host_to_dsp_flag_b = st_q.wr_byte[HC_FLAG_B];
					st_d.transfer_mode_low = st_q.wr_byte[HC_MODE_LO];
					st_d.transfer_mode_high = st_q.wr_byte[HC_MODE_HI];
					if (st_q.wr_byte[HC_INIT]) begin
						st_d.dma_cnt = st_q.wr_byte[HC_MODE_HI:HC_MODE_LO];
						if (st_q.wr_byte[HC_TX_REQ]) begin
							st_d.host_transmit_empty = 1'b1;
							st_d.dsp_receive_full = 1'b0;
						end
						if (st_q.wr_byte[HC_RX_REQ]) begin
							st_d.host_receive_full = 1'b0;
							st_d.dsp_transmit_empty = 1'b1;
						end
					end
				end
				HA_VECTOR: begin
					// A host request in the acknowledge cycle wins
					st_d.command_vector = st_q.wr_byte[VEC_W-1:0];
					st_d.command_pending = st_q.wr_byte[CV_REQ];
				end
				HA_IRQ_VEC: st_d.host_irq_vector = st_q.wr_byte;
				HA_HIGH: dt_d.host_transmit_bytes[23:16] = st_q.wr_byte;
				HA_MID: dt_d.host_transmit_bytes[15:8] = st_q.wr_byte;
				HA_LOW: begin
					dt_d.host_transmit_bytes[7:0] = st_q.wr_byte;
					st_d.host_transmit_empty = 1'b0;
				end
				default: ;
			endcase
		end
		if (rd_end && st_q.acc_addr == HA_LOW) begin
			st_d.host_receive_full = 1'b0;
		end
		// Counter wraps to the mode value so words stay aligned
		if ((wr_end | rd_end) && st_q.acc_dma) begin
			if (st_q.dma_cnt == DMA_CNT_LAST) begin
				st_d.dma_cnt = {st_q.transfer_mode_high,
					st_q.transfer_mode_low};
			end else begin
				st_d.dma_cnt = st_q.dma_cnt + 2'h1;
			end
		end
		// Word moves come after the access clears, so a set wins over them; sync_rst comes last and clears
		if (rx_move) begin
			dt_d.dsp_receive_word = dt_q.host_transmit_bytes;
			st_d.dsp_receive_full = 1'b1;
			st_d.host_transmit_empty = 1'b1;
		end
		if (tx_move) begin
			dt_d.host_receive_bytes = dt_q.dsp_transmit_word;
			st_d.host_receive_full = 1'b1;
			st_d.dsp_transmit_empty = 1'b1;
		end
		if (sync_rst) begin
			st_d.dsp_receive_full = 1'b0;
			st_d.dsp_transmit_empty = 1'b1;
			st_d.host_receive_full = 1'b0;
			st_d.host_transmit_empty = 1'b1;
			st_d.command_pending = 1'b0;
			st_d.host_to_dsp_flag_a = 1'b0;
			st_d.host_to_dsp_flag_b = 1'b0;
			st_d.transfer_mode_low = 1'b0;
			st_d.transfer_mode_high = 1'b0;
			st_d.rx_req_enable = 1'b0;
			st_d.tx_req_enable = 1'b0;
			st_d.dma_cnt = MODE_IRQ;
			if (soft_reset_i) begin
				st_d.receive_irq_enable = 1'b0;
				st_d.transmit_irq_enable = 1'b0;
				st_d.command_irq_enable = 1'b0;
				st_d.dsp_to_host_flag_a = 1'b0;
				st_d.dsp_to_host_flag_b = 1'b0;
			end
		end
		// Registered request and interrupt outputs follow the next state; read data follows the current state
		if (dsp_rd_i) begin
			case (dsp_sel_i)
				SEL_CONTROL: st_d.rdata = {16'h0000, 3'h0,
					st_q.dsp_to_host_flag_b, st_q.dsp_to_host_flag_a,
					st_q.command_irq_enable, st_q.transmit_irq_enable,
					st_q.receive_irq_enable};
				SEL_STATUS: st_d.rdata = {16'h0000, dsp_status(st_q)};
				SEL_DATA: st_d.rdata = dt_q.dsp_receive_word;
				default: st_d.rdata = 24'h000000;
			endcase
		end
		st_d.host_oe = rd_act;
		st_d.host_out = rd_act ? host_byte(st_q, dt_q, acc_addr) : 8'h00;
		st_d.host_req_n = ~host_req(st_d);
		st_d.rx_irq = st_d.dsp_receive_full & st_d.receive_irq_enable;
		st_d.tx_irq = st_d.dsp_transmit_empty & st_d.transmit_irq_enable;
		st_d.cmd_irq = st_d.command_pending & st_d.command_irq_enable;
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_q <= '0;
			st_q.dsp_transmit_empty <= 1'b1;
			st_q.host_transmit_empty <= 1'b1;
			st_q.host_req_n <= 1'b1;
			st_q.host_irq_vector <= IRQ_VEC_RST;
		end else begin
			st_q <= st_d;
		end
	end

	// No reset here: the words survive every reset
	always_ff @(posedge clk_i) begin
		dt_q <= dt_d;
	end

	assign dsp_rdata_o = st_q.rdata;
	assign receive_irq_o = st_q.rx_irq;
	assign transmit_irq_o = st_q.tx_irq;
	assign command_irq_o = st_q.cmd_irq;
	assign command_vector_o = st_q.command_vector;
	assign host_data_o = st_q.host_out;
	assign host_data_oe_o = st_q.host_oe;
	assign host_request_pin_n_o = st_q.host_req_n;

	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	dma_flag_a: assert property ((dsp_rd_i && dsp_sel_i == SEL_STATUS)
		|=> dsp_rdata_o[ST_DMA] == $past(dma_on) && dsp_rdata_o[6:5] == 2'h0)
		else $error("DMA status bit does not follow mode bits");

	rx_move_a: assert property ((rx_move && !sync_rst) |=>
		st_q.dsp_receive_full && st_q.host_transmit_empty &&
		dt_q.dsp_receive_word == $past(dt_q.host_transmit_bytes))
		else $error("host word not moved to receive word");

	rx_clear_a: assert property ((dsp_rx_rd && !rx_move)
		|=> !st_q.dsp_receive_full && !receive_irq_o)
		else $error("receive read did not clear full flag");

	tx_write_a: assert property ((dsp_tx_wr && !tx_move && !sync_rst)
		|=> !st_q.dsp_transmit_empty && !transmit_irq_o)
		else $error("transmit write did not clear empty flag");

	tx_move_a: assert property ((tx_move && !sync_rst) |=>
		st_q.host_receive_full && st_q.dsp_transmit_empty &&
		dt_q.host_receive_bytes == $past(dt_q.dsp_transmit_word))
		else $error("transmit word not moved to host bytes");

	reset_flags_a: assert property (sync_rst |=>
		st_q.dsp_transmit_empty && !st_q.dsp_receive_full &&
		!st_q.command_pending && !dma_on && !st_q.host_to_dsp_flag_a)
		else $error("reset left status flags set");

	ctrl_keep_a: assert property ((stop_reset_i && !soft_reset_i &&
		!dsp_ctl_wr) |=> $stable({st_q.receive_irq_enable,
		st_q.transmit_irq_enable, st_q.command_irq_enable,
		st_q.dsp_to_host_flag_a, st_q.dsp_to_host_flag_b}))
		else $error("stop reset changed control bits");

	cmd_ack_a: assert property ((irq_ack_cmd_i && !wr_end)
		|=> !st_q.command_pending && !command_irq_o)
		else $error("command acknowledge did not clear pending");

	irq_hold_a: assert property ((receive_irq_o && !dsp_rx_rd &&
		!dsp_ctl_wr && !sync_rst && !wr_end) |=> receive_irq_o)
		else $error("receive request dropped without access");

endmodule

// >>> hdl/host_port_pkg.sv
// Constants shared by the host port DSP-side datapath
package host_port_pkg;

	localparam int WORD_W = 24;
	localparam int BYTE_W = 8;
	localparam int VEC_W = 7;

	// DSP core register select
	localparam logic [1:0] SEL_CONTROL = 2'h0;
	localparam logic [1:0] SEL_STATUS = 2'h1;
	localparam logic [1:0] SEL_DATA = 2'h2;

	// dsp_port_control bit positions
	localparam int CTL_RX_IE = 0;
	localparam int CTL_TX_IE = 1;
	localparam int CTL_CMD_IE = 2;
	localparam int CTL_FLAG_A = 3;
	localparam int CTL_FLAG_B = 4;

	// dsp_port_status bit positions
	localparam int ST_RX_FULL = 0;
	localparam int ST_TX_EMPTY = 1;
	localparam int ST_CMD = 2;
	localparam int ST_FLAG_A = 3;
	localparam int ST_FLAG_B = 4;
	localparam int ST_DMA = 7;

	// Host byte map
	localparam logic [2:0] HA_CONTROL = 3'h0;
	localparam logic [2:0] HA_VECTOR = 3'h1;
	localparam logic [2:0] HA_STATUS = 3'h2;
	localparam logic [2:0] HA_IRQ_VEC = 3'h3;
	localparam logic [2:0] HA_HIGH = 3'h5;
	localparam logic [2:0] HA_MID = 3'h6;
	localparam logic [2:0] HA_LOW = 3'h7;

	// host_side_control bit positions
	localparam int HC_RX_REQ = 0;
	localparam int HC_TX_REQ = 1;
	localparam int HC_FLAG_A = 3;
	localparam int HC_FLAG_B = 4;
	localparam int HC_MODE_LO = 5;
	localparam int HC_MODE_HI = 6;
	localparam int HC_INIT = 7;

	// host_side_status bit positions
	localparam int HS_RX_FULL = 0;
	localparam int HS_TX_EMPTY = 1;
	localparam int HS_TX_READY = 2;
	localparam int HS_FLAG_A = 3;
	localparam int HS_FLAG_B = 4;
	localparam int HS_REQ = 7;

	// command_vector request bit
	localparam int CV_REQ = 7;

	// Transfer modes
	localparam logic [1:0] MODE_IRQ = 2'h0;
	localparam logic [1:0] MODE_DMA24 = 2'h1;
	localparam logic [1:0] MODE_DMA16 = 2'h2;
	localparam logic [1:0] MODE_DMA8 = 2'h3;
	localparam logic [1:0] DMA_CNT_LAST = 2'h3;

	localparam logic [1:0] CFG_OFF = 2'h0;
	localparam logic [7:0] IRQ_VEC_RST = 8'h0F;

	// Pin sample vector: ack_n, cs_n, rd_n, wr_n, select lines, data
	localparam int SYNC_W = 15;
	localparam logic [14:0] PIN_IDLE = 15'h7800;

endpackage

// >>> hdl/pin_sync.sv
// Two-stage synchroniser for the asynchronous host pins
`timescale 1ns/1ps
module pin_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] IDLE = '0
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	typedef struct packed {
		logic [W-1:0] first;
		logic [W-1:0] second;
	} sync_state_t;

	sync_state_t st_q;
	sync_state_t st_d;

	// First stage feeds only the second
	always_comb begin
		st_d.first = async_i;
		st_d.second = st_q.first;
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_q <= {IDLE, IDLE};
		end else begin
			st_q <= st_d;
		end
	end

	assign sync_o = st_q.second;
endmodule

// >>> test/host_model.sv
// Behavioural host processor on the byte-wide host pins
`timescale 1ns/1ps
module host_model (
	input wire logic clk_i,
	input wire logic [7:0] dut_data_i,
	input wire logic dut_oe_i,
	output logic [7:0] bus_o,
	output logic [2:0] sel_o,
	output logic cs_n_o,
	output logic rd_n_o,
	output logic wr_n_o,
	output logic ack_n_o
);
	logic [7:0] val_q;
	logic drive_q;

	// A released bus shows the inverse of the last byte, never a stale copy
	assign bus_o = dut_oe_i ? dut_data_i : (drive_q ? val_q : ~val_q);

	initial begin
		val_q = 8'h00;
		drive_q = 1'b0;
		sel_o = 3'h0;
		cs_n_o = 1'b1;
		rd_n_o = 1'b1;
		wr_n_o = 1'b1;
		ack_n_o = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// One byte access; strobe and gap of six clocks beat the four minimum.
	// The request pin is not waited on: the port is used as fast memory.
	task automatic access(input logic [2:0] a, input logic wr,
		input logic [7:0] d, output logic [7:0] q);
		@(posedge clk_i);
		sel_o <= a;
		val_q <= d;
		drive_q <= wr;
		cs_n_o <= 1'b0;
		rd_n_o <= wr;
		wr_n_o <= !wr;
		repeat (6) @(posedge clk_i);
		q = bus_o;
		cs_n_o <= 1'b1;
		rd_n_o <= 1'b1;
		wr_n_o <= 1'b1;
		repeat (6) @(posedge clk_i);
		drive_q <= 1'b0;
	endtask

	// DMA byte write: acknowledge instead of chip select, and the select
	// lines left on control so only the internal counter can pick a byte
	task automatic dma_access(input logic [7:0] d);
		@(posedge clk_i);
		sel_o <= 3'h0;
		val_q <= d;
		drive_q <= 1'b1;
		ack_n_o <= 1'b0;
		wr_n_o <= 1'b0;
		repeat (6) @(posedge clk_i);
		ack_n_o <= 1'b1;
		wr_n_o <= 1'b1;
		repeat (6) @(posedge clk_i);
		drive_q <= 1'b0;
	endtask
endmodule

// >>> test/host_port_dsp_side_datapath_bench.sv
// Self-checking bench for the DSP-side host port datapath
`timescale 1ns/1ps
module host_port_dsp_side_datapath_bench;
	import host_port_pkg::*;
	typedef struct packed {
		logic [1:0] mode;
		logic dma;
		logic [23:0] word;
	} row_t;
	row_t rows [4] = '{'{2'h0, 1'b0, 24'h000001}, '{2'h1, 1'b1, 24'hFFFFFF},
		'{2'h2, 1'b1, 24'hA5C30F}, '{2'h3, 1'b1, 24'h800080}};
	logic clk_i, rstn_i, soft_reset_i, stop_reset_i, irq_ack_cmd_i;
	logic dsp_rd_i, dsp_wr_i;
	logic [1:0] port_configuration_i, dsp_sel_i;
	logic [23:0] dsp_wdata_i, dsp_rdata_o, q, q2;
	logic receive_irq_o, transmit_irq_o, command_irq_o;
	logic [6:0] command_vector_o;
	logic [7:0] bus, hd_out, hb;
	logic [2:0] hsel;
	logic hd_oe, hcs_n, hrd_n, hwr_n, host_acknowledge_pin_n, host_request_pin_n;
	int num_errors = 0;
	int samples_checked = 0;

	host_port_dsp_side_datapath u_dut (.clk_i(clk_i), .rstn_i(rstn_i),
		.soft_reset_i(soft_reset_i), .stop_reset_i(stop_reset_i),
		.port_configuration_i(port_configuration_i), .dsp_sel_i(dsp_sel_i),
		.dsp_rd_i(dsp_rd_i), .dsp_wr_i(dsp_wr_i), .dsp_wdata_i(dsp_wdata_i),
		.dsp_rdata_o(dsp_rdata_o), .irq_ack_cmd_i(irq_ack_cmd_i),
		.receive_irq_o(receive_irq_o), .transmit_irq_o(transmit_irq_o),
		.command_irq_o(command_irq_o), .command_vector_o(command_vector_o),
		.host_data_i(bus), .host_data_o(hd_out), .host_data_oe_o(hd_oe),
		.register_select_lines_i(hsel), .host_cs_n_i(hcs_n),
		.host_rd_n_i(hrd_n), .host_wr_n_i(hwr_n),
		.host_acknowledge_pin_n_i(host_acknowledge_pin_n), .host_request_pin_n_o(host_request_pin_n));
	host_model u_host (.clk_i(clk_i), .dut_data_i(hd_out), .dut_oe_i(hd_oe),
		.bus_o(bus), .sel_o(hsel), .cs_n_o(hcs_n), .rd_n_o(hrd_n),
		.wr_n_o(hwr_n), .ack_n_o(host_acknowledge_pin_n));

	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [23:0] seen,
		input logic [23:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic dsp_wr(input logic [1:0] s, input logic [23:0] d);
		@(posedge clk_i);
		dsp_sel_i <= s;
		dsp_wdata_i <= d;
		dsp_wr_i <= 1'b1;
		@(posedge clk_i);
		dsp_wr_i <= 1'b0;
	endtask

	// Read data is registered, so it is sampled half a clock after taking
	task automatic dsp_rd(input logic [1:0] s, output logic [23:0] d);
		@(posedge clk_i);
		dsp_sel_i <= s;
		dsp_rd_i <= 1'b1;
		@(posedge clk_i);
		dsp_rd_i <= 1'b0;
		@(negedge clk_i);
		d = dsp_rdata_o;
	endtask

	task automatic wait_bit(input int b, input logic v);
		for (int i = 0; i < 40; i++) begin
			dsp_rd(SEL_STATUS, q);
			if (q[b] === v)
				break;
		end
		check("status poll", 24'(q[b]), 24'(v));
	endtask

	task automatic host_word(input logic wr, input logic [23:0] w,
		output logic [23:0] r);
		u_host.access(HA_HIGH, wr, w[23:16], r[23:16]);
		u_host.access(HA_MID, wr, w[15:8], r[15:8]);
		u_host.access(HA_LOW, wr, w[7:0], r[7:0]);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10000) @(posedge clk_i);
		num_errors++;
		tally_and_finish();
	end

	initial begin
		rstn_i = 1'b0;
		soft_reset_i = 1'b0;
		stop_reset_i = 1'b0;
		irq_ack_cmd_i = 1'b0;
		port_configuration_i = 2'h1;
		dsp_sel_i = 2'h3;
		dsp_rd_i = 1'b0;
		dsp_wr_i = 1'b0;
		dsp_wdata_i = 24'h000000;
		repeat (8) @(posedge clk_i);
		rstn_i <= 1'b1;
		dsp_rd(SEL_STATUS, q);
		check("status", q, 24'h000002);
		dsp_rd(SEL_CONTROL, q);
		check("control", q, 24'h000000);
		dsp_wr(SEL_CONTROL, 24'h000007);
		$display("reset test done");
		foreach (rows[i]) begin
			u_host.access(HA_CONTROL, 1'b1, {1'b0, rows[i].mode, 5'h00}, hb);
			dsp_rd(SEL_STATUS, q);
			check("dma bit", 24'(q[ST_DMA]), 24'(rows[i].dma));
			host_word(1'b1, rows[i].word, q2);
			wait_bit(ST_RX_FULL, 1'b1);
			check("rx irq", 24'(receive_irq_o), 24'h1);
			dsp_rd(SEL_DATA, q);
			check("rx word", q, rows[i].word);
			@(negedge clk_i);
			check("rx irq off", 24'(receive_irq_o), 24'h0);
			dsp_rd(SEL_STATUS, q);
			check("rx full", 24'(q[ST_RX_FULL]), 24'h0);
			// Second word written early on purpose, while the first waits
			dsp_wr(SEL_DATA, rows[i].word ^ 24'h5A5A5A);
			dsp_wr(SEL_DATA, ~rows[i].word);
			dsp_rd(SEL_STATUS, q);
			check("tx empty", 24'(q[ST_TX_EMPTY]), 24'h0);
			check("tx irq", 24'(transmit_irq_o), 24'h0);
			host_word(1'b0, 24'h000000, q);
			check("host rx", q, rows[i].word ^ 24'h5A5A5A);
			wait_bit(ST_TX_EMPTY, 1'b1);
			check("tx irq on", 24'(transmit_irq_o), 24'h1);
			host_word(1'b0, 24'h000000, q);
			check("host rx 2", q, ~rows[i].word);
			$display("row %0d done", i);
		end
		for (int v = 0; v < 2; v++) begin
			u_host.access(HA_VECTOR, 1'b1, {1'b1, v ? 7'h7F : 7'h00}, hb);
			for (int n = 0; n < 20 && command_irq_o !== 1'b1; n++)
				@(negedge clk_i);
			check("cmd irq", 24'(command_irq_o), 24'h1);
			check("cmd vec", 24'(command_vector_o), v ? 24'h7F : 24'h0);
			dsp_rd(SEL_STATUS, q);
			check("cmd pend", 24'(q[ST_CMD]), 24'h1);
			@(posedge clk_i);
			irq_ack_cmd_i <= 1'b1;
			@(posedge clk_i);
			irq_ack_cmd_i <= 1'b0;
			repeat (3) @(negedge clk_i);
			check("cmd irq off", 24'(command_irq_o), 24'h0);
			$display("command %0d done", v);
		end
		for (int k = 0; k < 4; k++) begin
			dsp_wr(SEL_CONTROL, 24'h00001F);
			u_host.access(HA_CONTROL, 1'b1, 8'h38, hb);
			dsp_rd(SEL_STATUS, q);
			dsp_rd(SEL_STATUS, q2);
			check("flags agree", q, q2);
			check("flags", q, 24'h00009A);
			@(posedge clk_i);
			case (k)
				0: soft_reset_i <= 1'b1;
				1: stop_reset_i <= 1'b1;
				2: port_configuration_i <= CFG_OFF;
				default: rstn_i <= 1'b0;
			endcase
			repeat (2) @(posedge clk_i);
			soft_reset_i <= 1'b0;
			stop_reset_i <= 1'b0;
			port_configuration_i <= 2'h1;
			rstn_i <= 1'b1;
			dsp_rd(SEL_STATUS, q);
			check("status rst", q, 24'h000002);
			dsp_rd(SEL_CONTROL, q);
			check("control rst", q, (k == 1 || k == 2) ? 24'h1F : 24'h0);
			dsp_rd(SEL_DATA, q);
			check("rx word kept", q, rows[3].word);
			$display("reset kind %0d done", k);
		end
		// Init with 24-bit DMA, host to DSP; second word waits on full
		u_host.access(HA_CONTROL, 1'b1, 8'hA2, hb);
		@(negedge clk_i);
		check("request on", 24'(host_request_pin_n), 24'h0);
		u_host.dma_access(8'h13);
		u_host.dma_access(8'h57);
		u_host.dma_access(8'h9B);
		u_host.dma_access(8'h24);
		u_host.dma_access(8'h68);
		u_host.dma_access(8'hAC);
		@(negedge clk_i);
		check("request off", 24'(host_request_pin_n), 24'h1);
		dsp_rd(SEL_DATA, q);
		check("dma word 1", q, 24'h13579B);
		wait_bit(ST_RX_FULL, 1'b1);
		check("request again", 24'(host_request_pin_n), 24'h0);
		dsp_rd(SEL_DATA, q);
		check("dma word 2", q, 24'h2468AC);
		$display("dma test done");
		tally_and_finish();
	end
endmodule
